// File: testbench/didb_contact.sv
// Purpose: sampled field contact feeding the raw input bus
// Assumes: contact levels are set by the bench
// Notes:   one sample a clock, like the converter ahead of the block
`timescale 1ns/1ps
`default_nettype none
module didb_contact (
  input  wire logic       mclk_in,
  input  wire logic [7:0] level_in,
  output logic      [7:0] raw_out
);
  initial raw_out = 8'h00;
  // Sampled once a clock, so bounce that starts and ends between two edges never shows
  always @(posedge mclk_in) raw_out <= #1 level_in;
endmodule // didb_contact
`default_nettype wire

// File: testbench/tb.sv
// Purpose: self-checking bench for the eight-input debounce block
// Assumes: 25 MHz clock, free-running 1 ms tick phased from reset release
// Notes:   checks avoid tick-phase windows; ac dropout is too long to run
`timescale 1ns/1ps
`default_nettype none
module tb;
  import didb_pkg::*;
  `define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    failures++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
  typedef struct {
    logic [7:0] lvl;
    int         cyc;
    logic [7:0] mask;
    logic [7:0] exp;
  } didb_row_t;
  logic         mclk_in    = 1'b0;
  logic         reset_n_in = 1'b0;
  logic [7:0]   level_r    = 8'h00;
  logic [7:0]   raw_w;
  logic [7:0]   ac_sel     = 8'h00;
  logic [127:0] delay_set  = '0;
  logic         load       = 1'b0;
  logic [7:0]   qual_w;
  logic [7:0]   rec_w;
  int           failures   = 0;
  int           checks     = 0;
  int           cycles     = 0;
  // Input 2 (ac) stays high from row 2 and picks up on the third tick
  didb_row_t    rows [8]   = '{
    '{8'h01, 3, 8'hFF, 8'h01},
    '{8'h00, 3, 8'hFF, 8'h00},
    '{8'hFF, 3, 8'hFF, 8'h01},
    '{8'hFF, 23747, 8'hFF, 8'h01},
    '{8'hFF, 26750, 8'hFF, 8'h03},
    '{8'h04, 3, 8'hFF, 8'h02},
    '{8'h04, 23747, 8'hFF, 8'h02},
    '{8'h04, 26750, 8'hFF, 8'h04}};

  didb_contact partner (
    .mclk_in (mclk_in),
    .level_in(level_r),
    .raw_out (raw_w)
  );

  didb_top uut (
    .mclk_in                       (mclk_in),
    .reset_n_in                    (reset_n_in),
    .raw_input_sample_in           (raw_w),
    .input_ac_select_in            (ac_sel),
    .input_qualify_delay_setting_in(delay_set),
    .setting_load_in               (load),
    .qualified_input_bit_out       (qual_w),
    .event_recorder_bit_out        (rec_w)
  );

  initial begin
    forever #20 mclk_in = ~mclk_in;
  end

  task automatic print_verdict();
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 110000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  initial begin
    step(10);
    `CHK("qual in reset", 8'h00, qual_w)
    reset_n_in = 1'b1;
    level_r = 8'hFF;
    step(4);
    `CHK("qual default", 8'h00, qual_w)
    level_r = 8'h00;
    // In4 asks for 65001 and keeps its default; in1 then must keep 1 ms
    delay_set = {{3{16'd65000}}, 16'd65001, 16'd4, 16'd0, 16'd1, 16'd0};
    ac_sel = 8'h04;
    load = 1'b1;
    step(1);
    delay_set[31:16] = 16'd65001;
    step(1);
    load = 1'b0;
    step(1);
    foreach (rows[i]) begin
      level_r = rows[i].lvl;
      step(rows[i].cyc);
      `CHK("qualified", rows[i].exp, qual_w & rows[i].mask)
      `CHK("recorder", rows[i].exp, rec_w & rows[i].mask)
    end
    reset_n_in = 1'b0;
    step(2);
    `CHK("qual rereset", 8'h00, qual_w)
    `CHK("rec rereset", 8'h00, rec_w)
    print_verdict();
  end
endmodule // tb
`default_nettype wire

// File: verilog/didb_chan.sv
// Purpose: pickup/dropout timer for one contact input
// Assumes: delays in ms, counted on the shared 1 ms tick
// Notes:   zero delay passes the raw sample through in one cycle
`timescale 1ns/1ps
`include "didb_map.svh"
`default_nettype none
module didb_chan
  import didb_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic        tick_in,
  input  wire logic        raw_in,
  input  wire logic [15:0] pu_ms_in,
  input  wire logic [15:0] do_ms_in,
  output logic             qual_out
);
  didb_state_t st_r;
  didb_state_t st_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        q_r;
  logic        q_nxt;

  // Stay must exceed the delay, so expiry is one tick past the setting
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    q_nxt   = q_r;
    case (st_r)
      DIDB_ST_LOW: begin
        q_nxt = 1'b0;
        if (raw_in) begin
          if (pu_ms_in == 16'h0000) begin // see [R04]
            st_nxt = DIDB_ST_HIGH;
            q_nxt  = 1'b1;
          end else begin
            st_nxt  = DIDB_ST_PU; // see [R07]
            cnt_nxt = 16'h0000;
          end
        end
      end
      DIDB_ST_PU: begin
        if (!raw_in) begin
          st_nxt = DIDB_ST_LOW; // see [R07]
        end else if (tick_in) begin
          if (cnt_r >= pu_ms_in) begin
            st_nxt = DIDB_ST_HIGH; // see [R08]
            q_nxt  = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 16'h0001;
          end
        end
      end
      DIDB_ST_HIGH: begin
        q_nxt = 1'b1;
        if (!raw_in) begin
          if (do_ms_in == 16'h0000) begin // see [R04]
            st_nxt = DIDB_ST_LOW;
            q_nxt  = 1'b0;
          end else begin
            st_nxt  = DIDB_ST_DO; // see [R09]
            cnt_nxt = 16'h0000;
          end
        end
      end
      DIDB_ST_DO: begin
        if (raw_in) begin
          st_nxt = DIDB_ST_HIGH;
        end else if (tick_in) begin
          if (cnt_r >= do_ms_in) begin
            st_nxt = DIDB_ST_LOW; // see [R09]
            q_nxt  = 1'b0;
          end else begin
            cnt_nxt = cnt_r + 16'h0001;
          end
        end
      end
      default: begin
        st_nxt = DIDB_ST_LOW;
        q_nxt  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      st_r  <= DIDB_ST_LOW; // see [R12]
      cnt_r <= 16'h0000;
      q_r   <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      q_r   <= q_nxt;
    end
  end

  assign qual_out = q_r;

  chk_zero_follow: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R04]
    (st_r == DIDB_ST_LOW && raw_in && pu_ms_in == 16'h0000) |=> qual_out)
    else $error("zero delay did not pass rise");
  chk_short_pulse: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R07]
    (st_r == DIDB_ST_PU && !raw_in) |=> !qual_out)
    else $error("short pulse reached output");
  chk_rise_cause: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R08]
    $rose(qual_out) |-> $past(raw_in))
    else $error("output rose without raw high");
  chk_fall_cause: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R09]
    $fell(qual_out) |-> $past(!raw_in))
    else $error("output fell without raw low");
endmodule // didb_chan
`default_nettype wire

// File: verilog/didb_map.svh
// Purpose: constants for the eight-input debounce block
// Assumes: 25 MHz clock, 1 ms timer tick
// Notes:   times in ms, tick count derived from the clock rate
`ifndef DIDB_MAP_SVH
`define DIDB_MAP_SVH
`define DIDB_CLK_HZ        25000000
`define DIDB_TICK_MS       1
`define DIDB_TICK_CYCLES   ((`DIDB_CLK_HZ / 1000) * `DIDB_TICK_MS)
`define DIDB_NUM_INPUTS    8
`define DIDB_DELAY_MAX_MS  16'd65000
`define DIDB_DELAY_DEF_MS  16'd10
`define DIDB_AC_PU_MS      16'd2
`define DIDB_AC_DO_MS      16'd16
`endif

// File: verilog/didb_pkg.sv
// Purpose: shared types of the debounce block
// Assumes: nothing beyond the map header
// Notes:   mode selects dc (numeric delay) or ac (fixed delays)
`default_nettype none
package didb_pkg;
  typedef enum logic [0:0] {
    DIDB_MODE_DC = 1'b0,
    DIDB_MODE_AC = 1'b1
  } didb_mode_t;
  typedef enum logic [1:0] {
    DIDB_ST_LOW  = 2'b00,
    DIDB_ST_PU   = 2'b01,
    DIDB_ST_HIGH = 2'b10,
    DIDB_ST_DO   = 2'b11
  } didb_state_t;
endpackage
`default_nettype wire

// File: verilog/didb_tick.sv
// Purpose: one-cycle 1 ms tick from the system clock
// Assumes: synchronous active-low reset
// Notes:   tick pulse is the only slow rate in the block
`timescale 1ns/1ps
`include "didb_map.svh"
`default_nettype none
module didb_tick (
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  output logic      tick_out
);
  localparam int TICK_N = `DIDB_TICK_CYCLES;
  logic [14:0] cnt_r;
  logic [14:0] cnt_nxt;
  logic        tick_r;
  logic        tick_nxt;

  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r + 15'h0001;
    if (cnt_r == 15'(TICK_N - 1)) begin
      cnt_nxt  = 15'h0000;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      cnt_r  <= 15'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_out = tick_r;
endmodule // didb_tick
`default_nettype wire

// File: verilog/didb_top.sv
// Purpose: eight-input contact debounce with dc and ac modes
// Assumes: raw samples synchronous to mclk_in, 25 MHz
// Notes:   qualified bits feed both logic and event recorder
//
// Behaviour
// [R01] Numeric setting selects dc mode, 0-65000 ms
// [R02] Raw sample through timer gives qualified bit
// [R03] Dc delay governs both pickup and dropout
// [R04] Zero dc delay passes raw without delay
// [R05] AC selection gives ac mode, no times
// [R06] Ac mode: 2 ms pickup, 16 ms dropout
// [R07] Rise starts pickup; early fall keeps zero
// [R08] High beyond pickup delay drives bit high
// [R09] Low beyond dropout delay drives bit low
// [R10] Same qualified bit feeds logic and recorder
// [R11] Eight own settings, default dc 10 ms
// [R12] 1 ms tick; reset clears timers, outputs
`timescale 1ns/1ps
`include "didb_map.svh"
`default_nettype none
module didb_top
  import didb_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic [7:0]  raw_input_sample_in,
  input  wire logic [7:0]  input_ac_select_in,
  input  wire logic [127:0] input_qualify_delay_setting_in,
  input  wire logic        setting_load_in,
  output logic [7:0]       qualified_input_bit_out,
  output logic [7:0]       event_recorder_bit_out
);
  localparam int N = `DIDB_NUM_INPUTS;
  logic            tick;
  logic [7:0]      qual;
  didb_mode_t      mode_r   [N];
  didb_mode_t      mode_nxt [N];
  logic [15:0]     dly_r    [N];
  logic [15:0]     dly_nxt  [N];

  // Settings held locally; load outside range is ignored
  always_comb begin
    for (int i = 0; i < N; i++) begin
      mode_nxt[i] = mode_r[i];
      dly_nxt[i]  = dly_r[i];
      if (setting_load_in) begin
        if (input_ac_select_in[i]) begin
          mode_nxt[i] = DIDB_MODE_AC; // see [R05]
        end else if (input_qualify_delay_setting_in[i*16 +: 16] <= `DIDB_DELAY_MAX_MS) begin
          mode_nxt[i] = DIDB_MODE_DC; // see [R01]
          dly_nxt[i]  = input_qualify_delay_setting_in[i*16 +: 16];
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    for (int i = 0; i < N; i++) begin
      if (!reset_n_in) begin
        mode_r[i] <= DIDB_MODE_DC; // see [R11]
        dly_r[i]  <= `DIDB_DELAY_DEF_MS;
      end else begin
        mode_r[i] <= mode_nxt[i];
        dly_r[i]  <= dly_nxt[i];
      end
    end
  end

  didb_tick u_tick (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .tick_out   (tick) // see [R12]
  );

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      logic [15:0] pu;
      logic [15:0] dn;
      assign pu = (mode_r[g] == DIDB_MODE_AC) ? `DIDB_AC_PU_MS : dly_r[g]; // see [R06] [R03]
      assign dn = (mode_r[g] == DIDB_MODE_AC) ? `DIDB_AC_DO_MS : dly_r[g]; // see [R06] [R03]
      didb_chan u_ch (
        .mclk_in    (mclk_in),
        .reset_n_in (reset_n_in),
        .tick_in    (tick),
        .raw_in     (raw_input_sample_in[g]),
        .pu_ms_in   (pu),
        .do_ms_in   (dn),
        .qual_out   (qual[g]) // see [R02]
      );
      chk_ac_fixed: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R06]
        (mode_r[g] == DIDB_MODE_AC) |-> (pu == 16'h0002 && dn == 16'h0010))
        else $error("ac delays not fixed");
      chk_dc_both: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R03]
        (mode_r[g] == DIDB_MODE_DC) |-> (pu == dly_r[g] && dn == dly_r[g]))
        else $error("dc delay not shared");
      chk_range_kept: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R01]
        dly_r[g] <= `DIDB_DELAY_MAX_MS)
        else $error("delay out of range");
      chk_load_taken: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R01]
        (setting_load_in && !input_ac_select_in[g]
         && input_qualify_delay_setting_in[g*16 +: 16] <= `DIDB_DELAY_MAX_MS)
        |=> (mode_r[g] == DIDB_MODE_DC
             && dly_r[g] == $past(input_qualify_delay_setting_in[g*16 +: 16])))
        else $error("dc delay not loaded");
      chk_over_ignored: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R01]
        (setting_load_in && !input_ac_select_in[g]
         && input_qualify_delay_setting_in[g*16 +: 16] > `DIDB_DELAY_MAX_MS)
        |=> ($stable(dly_r[g]) && $stable(mode_r[g])))
        else $error("out of range delay accepted");
      chk_ac_taken: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R05]
        (setting_load_in && input_ac_select_in[g]) |=> (mode_r[g] == DIDB_MODE_AC))
        else $error("ac selection not taken");
    end
  endgenerate

  // One source for both consumers keeps stamps aligned with logic
  assign qualified_input_bit_out = qual; // see [R10]
  assign event_recorder_bit_out  = qual; // see [R10]

  chk_reset_clear: assert property (@(posedge mclk_in) // see [R12]
    !reset_n_in |=> (qualified_input_bit_out == 8'h00))
    else $error("outputs not cleared by reset");
  chk_recorder_same: assert property (@(posedge mclk_in) disable iff (!reset_n_in) // see [R10]
    event_recorder_bit_out == qualified_input_bit_out)
    else $error("recorder bit differs");
endmodule // didb_top
`default_nettype wire
